// ---- rx_irq_pkg.sv ----
/*
  Shared constants and types for the receiver status and interrupt
  block: register offsets, reset values, field positions, trigger
  modes and the packed carriers used between the modules.
  Assumes an 8-bit register port with 8-bit addresses.
*/
package rx_irq_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_SLIP_STATUS   = 8'h15;
  localparam logic [7:0] ADDR_ENABLE_ONE    = 8'h16;
  localparam logic [7:0] ADDR_ENABLE_TWO    = 8'h17;
  localparam logic [7:0] ADDR_TRIGGER_ONE   = 8'h18;
  localparam logic [7:0] ADDR_EVENT_FLAGS   = 8'h40;
  localparam logic [7:0] ADDR_SLIP_FLAG     = 8'h41;

  // Reset values
  localparam logic [7:0] RST_ENABLE_ONE     = 8'h00;
  localparam logic [7:0] RST_ENABLE_TWO     = 8'h00;
  localparam logic [7:0] RST_TRIGGER_ONE    = 8'h00;
  localparam logic [7:0] RST_READ_DATA      = 8'h00;

  // Field positions
  localparam int BIT_SLIP                   = 0;
  localparam int BIT_VALIDITY_ENABLE        = 5;
  localparam int BIT_BUFFER_TRANSFER_ENABLE = 0;
  localparam int LSB_SUBCODE_CHANGE_TRIGGER = 6;
  localparam int LSB_LOCK_LOSS_TRIGGER      = 4;
  localparam int LSB_SUBCODE_CRC_TRIGGER    = 2;
  localparam int LSB_BUFFER_TRANSFER_TRIGGER = 0;

  // Source count: eight receiver sources plus the slip error
  localparam int NUM_RX_SOURCES             = 8;
  localparam int NUM_SOURCES                = 9;
  localparam int IDX_SLIP_SOURCE            = 8;

  typedef enum logic [1:0]
  {
    TRIG_RISE     = 2'b00,
    TRIG_FALL     = 2'b01,
    TRIG_LEVEL    = 2'b10,
    TRIG_RESERVED = 2'b11
  } trigger_mode_t;

  // Bit 7 down to bit 0, same layout as the first enable register
  typedef struct packed
  {
    logic chan_status_crc_error;
    logic parity_error;
    logic validity_flag;
    logic biphase_error;
    logic subcode_changed;
    logic lock_loss;
    logic subcode_crc_error;
    logic buffer_transfer_done;
  } rx_status_t;

  typedef struct packed
  {
    logic port_a_from_rx;
    logic port_a_slave;
    logic port_a_slip;
    logic port_b_from_rx;
    logic port_b_slave;
    logic port_b_slip;
  } slip_route_t;

  typedef struct packed
  {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

endpackage

// ---- trigger_detect.sv ----
/*
  One interrupt trigger detector: turns a status level into a set
  request according to a 2-bit trigger mode.
  Assumes the level is synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module trigger_detect
  import rx_irq_pkg::*;
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          sys_rst,
  // Source and mode
  input  wire logic          level,
  input  wire trigger_mode_t mode,
  output logic               fire
);

  logic prev;
  logic next_prev;

  always_comb
  begin
    next_prev = level;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      prev <= 1'b0;
    else
      prev <= next_prev;
  end

  always_comb
  begin
    unique case (mode)
      TRIG_RISE:     fire = level & ~prev;
      TRIG_FALL:     fire = ~level & prev;
      TRIG_LEVEL:    fire = level;
      // Reserved code never fires
      TRIG_RESERVED: fire = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// ---- sticky_flags.sv ----
/*
  Bank of sticky event flags, set by hardware and cleared by a
  write-one-to-clear mask. Assumes set and clear are one-cycle terms.
*/
`timescale 1ns/1ps
`default_nettype none
module sticky_flags
#(
  parameter int WIDTH = 8
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Set and clear
  input  wire logic [WIDTH-1:0] set,
  input  wire logic [WIDTH-1:0] clr,
  output logic      [WIDTH-1:0] flags
);

  logic [WIDTH-1:0] next_flags;

  // Set wins over a clear in the same cycle
  always_comb
  begin
    next_flags = (flags & ~clr) | set;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      flags <= '0;
    else
      flags <= next_flags;
  end

endmodule
`default_nettype wire

// ---- rx_irq_ctrl.sv ----
/*
  Receiver status and interrupt masking: slip status qualification,
  enable registers, trigger-mode register, sticky event flags and the
  single level interrupt request.
  Assumes status levels and the register port are synchronous to clk.
*/
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R1 - Slip status reads 1 after slip
// R2 - Slip status register read-only, upper bits zero
// R3 - Slip interrupt gated by enable at 0x17
// R4 - Slip only when rx port is slave
// R5 - Single rx-sourced port: track that port
// R6 - Both ports rx-sourced: track port A
// R7 - First enable register bit order fixed
// R8 - Enable zero masks, reset default zero
// R9 - Buffer-transfer interrupt needs bit zero enable
// R10 - Validity interrupt needs bit five enable
// R11 - Mode field: rise, fall, level, reserved
// R12 - Buffer-transfer status shows completion
// R13 - Unlock status shows lost lock
// R14 - Trigger register holds four 2-bit fields
// R15 - Request is OR of enabled triggered sources
module rx_irq_ctrl
  import rx_irq_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Register port
  input  wire reg_req_t    req,
  output logic [7:0]       rd_data,
  // Receiver status levels
  input  wire rx_status_t  rx_status,
  // Serial port routing and slip levels
  input  wire slip_route_t slip_route,
  // Interrupt request
  output logic             irq
);

  //////////////////////////////////////////////////////////////////////
  // Register decode

  logic wr_slip_flag;
  logic wr_enable_one;
  logic wr_enable_two;
  logic wr_trigger_one;
  logic wr_event_flags;

  always_comb
  begin
    wr_enable_one  = req.wr && (req.addr == ADDR_ENABLE_ONE);
    wr_enable_two  = req.wr && (req.addr == ADDR_ENABLE_TWO);
    wr_trigger_one = req.wr && (req.addr == ADDR_TRIGGER_ONE);
    wr_event_flags = req.wr && (req.addr == ADDR_EVENT_FLAGS);
    wr_slip_flag   = req.wr && (req.addr == ADDR_SLIP_FLAG);
  end

  //////////////////////////////////////////////////////////////////////
  // Enable and trigger-mode registers

  rx_status_t enable_one;
  rx_status_t next_enable_one;
  logic       slip_enable;
  logic       next_slip_enable;
  logic [7:0] trigger_one;
  logic [7:0] next_trigger_one;

  always_comb
  begin
    next_enable_one  = enable_one;
    next_slip_enable = slip_enable;
    next_trigger_one = trigger_one;
    if (wr_enable_one)
      next_enable_one = rx_status_t'(req.wdata);         // [R7]
    if (wr_enable_two)
      next_slip_enable = req.wdata[BIT_SLIP];            // [R3]
    if (wr_trigger_one)
      next_trigger_one = req.wdata;                      // [R14]
  end

  // All enables come up masked
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      enable_one  <= rx_status_t'(RST_ENABLE_ONE);       // [R8]
      slip_enable <= RST_ENABLE_TWO[BIT_SLIP];           // [R3]
      trigger_one <= RST_TRIGGER_ONE;                    // [R11]
    end
    else
    begin
      enable_one  <= next_enable_one;
      slip_enable <= next_slip_enable;
      trigger_one <= next_trigger_one;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Slip qualification

  // Port A has priority when both ports take the receiver output
  logic slip_level;

  always_comb
  begin
    if (slip_route.port_a_from_rx)                       // [R6]
      slip_level = slip_route.port_a_slave
                   & slip_route.port_a_slip;             // [R4]
    else if (slip_route.port_b_from_rx)                  // [R5]
      slip_level = slip_route.port_b_slave
                   & slip_route.port_b_slip;             // [R4]
    else
      slip_level = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////
  // Per-source trigger modes

  // Only four sources have a mode field here; the rest use the
  // rising-edge default so their behaviour matches reset.
  trigger_mode_t src_mode [NUM_SOURCES];
  logic [NUM_SOURCES-1:0] src_level;

  always_comb
  begin
    src_level = {slip_level, rx_status};
    for (int i = 0; i < NUM_SOURCES; i++)
      src_mode[i] = TRIG_RISE;
    src_mode[3] = trigger_mode_t'(
      trigger_one[LSB_SUBCODE_CHANGE_TRIGGER +: 2]);     // [R14]
    src_mode[2] = trigger_mode_t'(
      trigger_one[LSB_LOCK_LOSS_TRIGGER +: 2]);          // [R14]
    src_mode[1] = trigger_mode_t'(
      trigger_one[LSB_SUBCODE_CRC_TRIGGER +: 2]);        // [R14]
    src_mode[0] = trigger_mode_t'(
      trigger_one[LSB_BUFFER_TRANSFER_TRIGGER +: 2]);    // [R14]
  end

  //////////////////////////////////////////////////////////////////////
  // Trigger detection, one detector per source

  logic [NUM_SOURCES-1:0] src_fire;

  generate
    for (genvar g = 0; g < NUM_SOURCES; g++)
    begin : gen_trigger
      trigger_detect u_trigger
      (
        .clk     (clk),
        .sys_rst (sys_rst),
        .level   (src_level[g]),
        .mode    (src_mode[g]),
        .fire    (src_fire[g])                           // [R11]
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // Sticky event flags

  // Flags latch whatever the enables say; the enables only gate
  // the request, so software can poll a masked source.
  logic [NUM_SOURCES-1:0] flag_clr;
  logic [NUM_SOURCES-1:0] flags;

  always_comb
  begin
    flag_clr = '0;
    if (wr_event_flags)
      flag_clr[NUM_RX_SOURCES-1:0] = req.wdata;          // [R12] [R13]
    if (wr_slip_flag)
      flag_clr[IDX_SLIP_SOURCE] = req.wdata[BIT_SLIP];   // [R1]
  end

  sticky_flags
  #(
    .WIDTH (NUM_SOURCES)
  )
  u_flags
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .set     (src_fire),
    .clr     (flag_clr),
    .flags   (flags)                                     // [R1]
  );

  //////////////////////////////////////////////////////////////////////
  // Interrupt request

  logic [NUM_SOURCES-1:0] gated;
  logic                   next_irq;

  always_comb
  begin
    gated = flags & {slip_enable, enable_one};           // [R3] [R8]
    // Named bits kept visible for the two singled-out sources
    gated[BIT_BUFFER_TRANSFER_ENABLE] =
      flags[BIT_BUFFER_TRANSFER_ENABLE]
      & enable_one.buffer_transfer_done;                 // [R9]
    gated[BIT_VALIDITY_ENABLE] =
      flags[BIT_VALIDITY_ENABLE]
      & enable_one.validity_flag;                        // [R10]
    next_irq = |gated;                                   // [R15]
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irq <= 1'b0;
    else
      irq <= next_irq;
  end

  //////////////////////////////////////////////////////////////////////
  // Read data, valid only the cycle after the strobe

  logic [7:0] next_rd_data;
  logic [7:0] slip_view;
  logic [7:0] enable_two_view;

  always_comb
  begin
    slip_view = 8'h00;
    slip_view[BIT_SLIP] = flags[IDX_SLIP_SOURCE];        // [R1] [R2]
    enable_two_view = 8'h00;
    enable_two_view[BIT_SLIP] = slip_enable;
    next_rd_data = RST_READ_DATA;
    if (req.rd)
    begin
      unique case (req.addr)
        ADDR_SLIP_STATUS: next_rd_data = slip_view;      // [R2]
        ADDR_SLIP_FLAG:   next_rd_data = slip_view;
        ADDR_ENABLE_ONE:  next_rd_data = enable_one;
        ADDR_ENABLE_TWO:  next_rd_data = enable_two_view;
        ADDR_TRIGGER_ONE: next_rd_data = trigger_one;
        ADDR_EVENT_FLAGS:
          next_rd_data = flags[NUM_RX_SOURCES-1:0];      // [R12] [R13]
        default:          next_rd_data = RST_READ_DATA;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rd_data <= RST_READ_DATA;
    else
      rd_data <= next_rd_data;
  end

endmodule
`default_nettype wire

// ---- rx_irq_ctrl_properties.sv ----
/*
  Concurrent checks on the receiver interrupt block ports.
  Assumes one clock domain; shadows the enable and mode registers.
*/
`timescale 1ns/1ps
`default_nettype none
module rx_irq_props
  import rx_irq_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Register port
  input wire reg_req_t    req,
  input wire logic [7:0]  rd_data,
  // Sources and request
  input wire rx_status_t  rx_status,
  input wire slip_route_t slip_route,
  input wire logic        irq
);
  logic [7:0] en1;
  logic       en2;
  logic [7:0] trig;
  logic       sel;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////
  // Port A wins whenever it takes receiver data
  assign sel = slip_route.port_a_from_rx ?
    (slip_route.port_a_slave & slip_route.port_a_slip) :
    (slip_route.port_b_from_rx & slip_route.port_b_slave &
     slip_route.port_b_slip);
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      en1  <= 8'h00;
      en2  <= 1'b0;
      trig <= 8'h00;
    end
    else if (req.wr)
    begin
      if (req.addr == ADDR_ENABLE_ONE) en1 <= req.wdata;
      if (req.addr == ADDR_ENABLE_TWO) en2 <= req.wdata[0];
      if (req.addr == ADDR_TRIGGER_ONE) trig <= req.wdata;
    end
  end
  ////////////////////////////////////////////////////////////////////
  AST_RD_IDLE: assert property (!req.rd |=> rd_data == 8'h00)
    else $error("read data not idle");
  AST_RO_UPPER: assert property (
    req.rd && req.addr == ADDR_SLIP_STATUS |=> rd_data[7:1] == 7'h00)
    else $error("slip status upper bits set");
  AST_MASKED: assert property (
    (en1 == 8'h00 && !en2) [*2] |=> !irq)
    else $error("irq with all sources masked");
  AST_UNLOCK_RISE: assert property (
    $rose(rx_status.lock_loss) && en1[2] && trig[5:4] == 2'b00
    |-> ##2 irq) else $error("no irq on lock loss rise");
  AST_UNLOCK_FALL: assert property (
    $fell(rx_status.lock_loss) && en1[2] && trig[5:4] == 2'b01
    |-> ##2 irq) else $error("no irq on lock loss fall");
  AST_LEVEL: assert property (
    (rx_status.lock_loss && en1[2] && trig[5:4] == 2'b10) [*3]
    |-> irq) else $error("no irq in level mode");
  AST_VALIDITY: assert property (
    $rose(rx_status.validity_flag) && en1[5] |-> ##2 irq)
    else $error("no irq on validity");
  AST_BUFFER: assert property (
    $rose(rx_status.buffer_transfer_done) && en1[0] &&
    trig[1:0] == 2'b00 |-> ##2 irq) else $error("no buffer irq");
  AST_SLIP: assert property ($rose(sel) && en2 |-> ##2 irq)
    else $error("no irq on slip");
endmodule
bind rx_irq_ctrl rx_irq_props chk
(
  .clk        (clk),
  .sys_rst    (sys_rst),
  .req        (req),
  .rd_data    (rd_data),
  .rx_status  (rx_status),
  .slip_route (slip_route),
  .irq        (irq)
);
`default_nettype wire

// ---- test_receiver_status_interrupt_masking.sv ----
/*
  Self-checking bench for rx_irq_ctrl: registers, masking, trigger
  modes and slip routing. Assumes the checker is bound separately.
*/
`timescale 1ns/1ps
`default_nettype none
module test_receiver_status_interrupt_masking
  import rx_irq_pkg::*;
;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  reg_req_t    req = '0;
  logic [7:0]  rd_data;
  rx_status_t  rx_status = '0;
  slip_route_t slip_route = '0;
  logic        irq;
  logic        rd_prev = 1'b0;
  logic        f;
  logic [7:0]  v;
  logic [8:0]  expq[$];
  int          num_errors = 0;
  int          n_compared = 0;
  int          seed;
  logic [7:0]  adr[5] = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h33};
  // Route {a_from, a_slave, b_from, b_slave}, then slip seen on A, B
  logic [5:0]  rt[6] = '{6'h3E, 6'h2C, 6'h0D, 6'h08, 6'h32, 6'h00};

  always #25 clk = ~clk;

  rx_irq_ctrl dut
  (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .req        (req),
    .rd_data    (rd_data),
    .rx_status  (rx_status),
    .slip_route (slip_route),
    .irq        (irq)
  );
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (num_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge clk);
    req.wr    <= 1'b0;
  endtask
  // Expected irq and read data are noted now, compared later
  task automatic rd(input logic [7:0] a, input logic i,
                    input logic [7:0] d);
    @(posedge clk);
    expq.push_back({i, d});
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clk);
    req.rd   <= 1'b0;
  endtask
  // Hold levels long enough for flag and irq to settle
  task automatic put(input logic [7:0] s, input logic [5:0] r);
    @(posedge clk);
    rx_status  <= s;
    slip_route <= r;
    repeat (3) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    if (rd_prev)
      chk({irq, rd_data}, expq.pop_front());
    rd_prev <= req.rd;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    complete_run;
  end
  initial
  begin
    seed = $urandom(32'h52493c6b);
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (adr[i]) rd(adr[i], 1'b0, 8'h00);
    v = 8'($urandom);
    wr(8'h16, v);
    rd(8'h16, 1'b0, v);
    v = 8'($urandom);
    wr(8'h18, v);
    rd(8'h18, 1'b0, v);
    wr(8'h17, 8'h01);
    rd(8'h17, 1'b0, 8'h01);
    wr(8'h15, 8'hFF);
    rd(8'h15, 1'b0, 8'h00);
    wr(8'h18, 8'h00);
    wr(8'h17, 8'h00);
    wr(8'h16, 8'h00);
    // Flags set while masked, irq stays low
    put(8'hFF, 6'h00);
    put(8'h00, 6'h00);
    rd(8'h40, 1'b0, 8'hFF);
    wr(8'h40, 8'hFF);
    rd(8'h40, 1'b0, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h16, 8'h01 << i);
      put(8'h01 << i, 6'h00);
      put(8'h00, 6'h00);
      rd(8'h40, 1'b1, 8'h01 << i);
      wr(8'h40, 8'hFF);
    end
    wr(8'h16, 8'h0F);
    for (int k = 0; k < 4; k++)
      for (int m = 0; m < 4; m++)
      begin
        wr(8'h18, 8'(m << (2 * k)));
        put(8'h01 << k, 6'h00);
        f = (m == 0 || m == 2);
        rd(8'h40, f, {7'h00, f} << k);
        put(8'h00, 6'h00);
        f = (m != 3);
        rd(8'h40, f, {7'h00, f} << k);
        wr(8'h40, 8'hFF);
      end
    wr(8'h16, 8'h00);
    wr(8'h17, 8'h01);
    foreach (rt[j])
    begin
      put(8'h00, {rt[j][5:4], 1'b1, rt[j][3:2], 1'b0});
      rd(8'h15, rt[j][1], {7'h00, rt[j][1]});
      wr(8'h41, 8'h01);
      put(8'h00, {rt[j][5:4], 1'b0, rt[j][3:2], 1'b1});
      rd(8'h15, rt[j][0], {7'h00, rt[j][0]});
      wr(8'h41, 8'h01);
    end
    put(8'h00, 6'h38);
    wr(8'h17, 8'h00);
    rd(8'h15, 1'b0, 8'h01);
    repeat (2) @(posedge clk);
    complete_run;
  end
endmodule
`default_nettype wire
